// [sim/host_link_model.sv]
module host_link_model (
  // card bus
  output logic            sd_clk_o,
  output logic            sd_cmd_o,
  input  wire logic       sd_dat_i
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [63:0] rx;
  ////////////////////////////////////////////////////////////////////////////
  // clock stands high between frames, command line rests at its pull-up
  initial begin
    sd_clk_o = 1'b1;
    sd_cmd_o = 1'b1;
    rx = 64'h0;
  end
  // starts off the system clock grid, returns at the last rise
  task automatic shift(input logic [63:0] f, input int n);
    #0.3;
    for (int i = n - 1; i >= 0; i--) begin
      #62.5;
      sd_clk_o = 1'b0;
      sd_cmd_o = f[i];
      #62.5;
      sd_clk_o = 1'b1;
      rx = {rx[62:0], sd_dat_i};
    end
  endtask
endmodule // host_link_model

// [sim/tb.sv]
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys_i, srst_i, reg_wr_i, reg_rd_i, sd_clk, sd_cmd, sd_dat_o, sd_dat_oe_n_o;
  logic resp_valid_o, resp_busy_o, busy_o, app_cmd_o, data_start_o, data_dir_o, erase_go_o;
  logic [1:0]  erase_mode_o;
  logic [5:0]  resp_index_o;
  logic [7:0]  reg_addr_i;
  logic [15:0] data_len_o;
  logic [31:0] reg_wdata_i, reg_rdata_o, resp_status_o, erase_first_o, erase_last_o, d;
  int fail_count = 0;
  int tests_run = 0;
  // released data line floats to its pull-up
  wire logic dat_w = sd_dat_oe_n_o ? 1'b1 : sd_dat_o;
  card_cmd_core #(.NUM_GROUPS(32)) dut (.clk_sys_i, .srst_i, .reg_addr_i, .reg_wdata_i,
    .reg_wr_i, .reg_rd_i, .reg_rdata_o, .sd_clk_i(sd_clk), .sd_cmd_i(sd_cmd), .sd_dat_o,
    .sd_dat_oe_n_o, .resp_valid_o, .resp_index_o, .resp_status_o, .resp_busy_o, .busy_o,
    .app_cmd_o, .data_start_o, .data_dir_o, .data_len_o, .erase_go_o, .erase_mode_o,
    .erase_first_o, .erase_last_o);
  host_link_model hm (.sd_clk_o(sd_clk), .sd_cmd_o(sd_cmd), .sd_dat_i(dat_w));
  initial begin
    clk_sys_i = 1'b0;
    forever #4 clk_sys_i = ~clk_sys_i;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_wdata_i <= v;
    reg_wr_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    @(negedge clk_sys_i);
    v = reg_rdata_o;
  endtask
  task automatic cmd(input logic [5:0] idx, input logic [31:0] arg, input logic ans);
    logic got;
    got = 1'b0;
    hm.shift(64'({2'b01, idx, arg, 8'h01}), 48);
    repeat (12) begin
      @(negedge clk_sys_i);
      if (resp_valid_o === 1'b1) got = 1'b1;
      if (resp_valid_o === 1'b1) d = 32'({erase_go_o, data_start_o});
    end
    chk(32'(got), 32'(ans));
    if (ans) chk(32'(resp_index_o), 32'(idx));
  endtask
  task automatic prot(input logic [31:0] arg, input logic [31:0] exp);
    cmd(6'h1E, arg, 1'b1);
    hm.shift(64'hFFFF_FFFF_FFFF_FFFF, 51);
    chk(32'({hm.rx[50], hm.rx[1]}), 32'h0000_0001);
    chk(hm.rx[49:18], exp);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_prot();
    cmd(6'h1C, 32'h0000_0A00, 1'b1);
    chk(32'({resp_busy_o, busy_o}), 32'h0000_0003);
    cmd(6'h1C, 32'h0000_0000, 1'b1);
    prot(32'h0000_0000, 32'h0000_0021);
    prot(32'h0000_0800, 32'h0000_0002);
    cmd(6'h1D, 32'h0000_0A00, 1'b1);
    chk(32'(resp_busy_o), 32'h0000_0001);
    wr(card_cmd_pkg::REG_CONFIG, 32'h0000_0102);
    cmd(6'h1C, 32'h0000_0A00, 1'b1);
    prot(32'h0000_0000, 32'h0000_0005);
  endtask
  task automatic t_erase();
    logic [31:0] a [3] = '{32'h0000_0001, 32'h0000_0002, 32'h0000_0007};
    logic [1:0] m [3] = '{2'h1, 2'h2, 2'h0};
    cmd(6'h20, 32'h0000_1000, 1'b1);
    chk(erase_first_o, 32'h0000_1000);
    cmd(6'h21, 32'h0000_3000, 1'b1);
    chk(erase_last_o, 32'h0000_3000);
    for (int i = 0; i < 3; i++) begin
      cmd(6'h26, a[i], 1'b1);
      chk(32'({d[1], resp_busy_o, erase_mode_o}), 32'({2'b11, m[i]}));
    end
  endtask
  task automatic t_xfer();
    wr(card_cmd_pkg::REG_CONFIG, 32'h0000_0002);
    cmd(6'h28, 32'h0000_0000, 1'b1);
    chk(32'(resp_status_o[30]), 32'h0000_0000);
    cmd(6'h28, 32'h0000_0100, 1'b1);
    chk(32'({resp_status_o[30], d[0]}), 32'h0000_0002);
    wr(card_cmd_pkg::REG_STATUS, 32'h0000_0007);
    wr(card_cmd_pkg::REG_CONFIG, 32'h0000_000A);
    cmd(6'h28, 32'h0000_0100, 1'b1);
    chk(32'(resp_status_o[30]), 32'h0000_0000);
    wr(card_cmd_pkg::REG_BLOCK_LEN, 32'h0000_0100);
    cmd(6'h38, 32'h0000_0001, 1'b1);
    chk(32'({d[0], data_dir_o, data_len_o}), 32'h0003_0100);
    cmd(6'h38, 32'h0000_0000, 1'b1);
    chk(32'({data_dir_o, data_len_o}), 32'h0000_0200);
    wr(card_cmd_pkg::REG_CONFIG, 32'h0000_0003);
    cmd(6'h38, 32'h0000_0001, 1'b1);
    chk(32'({data_dir_o, data_len_o}), 32'h0001_0200);
  endtask
  task automatic t_lock();
    wr(card_cmd_pkg::REG_CONFIG, 32'h1234_0022);
    cmd(6'h28, 32'h0000_0000, 1'b1);
    cmd(6'h2A, 32'h0000_0000, 1'b1);
    chk(32'({data_dir_o, data_len_o}), 32'h0000_0100);
    cmd(6'h37, 32'h1234_0000, 1'b1);
    chk(32'(app_cmd_o), 32'h0000_0001);
    wr(card_cmd_pkg::REG_BLOCK_LEN, 32'h0000_0201);
    cmd(6'h2A, 32'h0000_0000, 1'b1);
    chk(32'({app_cmd_o, resp_status_o[29]}), 32'h0000_0001);
  endtask
  task automatic t_reserved();
    logic [5:0] r [6] = '{6'h1F, 6'h27, 6'h29, 6'h33, 6'h3C, 6'h3F};
    for (int i = 0; i < 9; i++) begin
      if (i == 6) wr(card_cmd_pkg::REG_CONFIG, 32'h0000_0003);
      cmd(i < 6 ? r[i] : 6'(22 + i), 32'h0000_0000, 1'b0);
      rd(card_cmd_pkg::REG_STATUS, d);
      chk(d & 32'h0000_0001, 32'h0000_0001);
      wr(card_cmd_pkg::REG_STATUS, 32'h0000_0007);
    end
  endtask
  task automatic print_verdict();
    if (fail_count == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    #400us;
    fail_count++;
    print_verdict();
  end
  initial begin
    srst_i = 1'b1;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    reg_addr_i = 8'h00;
    reg_wdata_i = 32'h0000_0000;
    repeat (2) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
    rd(card_cmd_pkg::REG_CONFIG, d);
    chk(d, 32'h0000_0002);
    rd(card_cmd_pkg::REG_BLOCK_LEN, d);
    chk(d, 32'h0000_0200);
    t_prot();
    t_erase();
    t_xfer();
    t_lock();
    t_reserved();
    print_verdict();
  end
endmodule // tb

// [verilog/card_cmd_core.sv]
// Overview of operation
// RULE1: a transfer crossing a physical block needs the matching cross-boundary flag.
// RULE2: capacity status 0 means byte addresses, 1 means 512-byte block addresses.
// RULE3: without partial writes, writes use the default block length.
// RULE4: command 28 sets the addressed group's protect bit, busy response.
// RULE5: protect group size comes from the protect_group_size field.
// RULE6: command 29 clears the addressed group's protect bit, busy response.
// RULE7: high-capacity cards refuse commands 28, 29 and 30.
// RULE8: command 30 sends 32 protect bits then 16 CRC bits on data.
// RULE9: payload bit 0 is the first addressed group, ascending.
// RULE10: groups beyond the valid range report 0.
// RULE11: command 32 stores the first erase block address, normal response.
// RULE12: command 33 stores the last erase block address, normal response.
// RULE13: command 38 erases, busy response; argument 1 discard, 2 full, else normal.
// RULE14: command 40 is accepted even while locked.
// RULE15: command 42 receives a block of the current block length.
// RULE16: host drives reserved lock argument and data bits as 0.
// RULE17: command 55 with matching card address marks the next command application.
// RULE18: command 56 argument bit 0 set reads from card, clear writes.
// RULE19: general transfer uses block length, or 512 on high capacity.
// RULE20: block length above 512 bytes flags a block length error.
// RULE21: host sends the application prefix before each application command.
// RULE22: reserved indices 31, 39, 41, 51, 60-63 do nothing; the core sends no response but sets the st_ill flag.
//
// Design decisions made here: the plain strobed port and the placing of the registers.
module card_cmd_core #(
  parameter int NUM_GROUPS = 256
) (
  // system
  input  wire logic        clk_sys_i,
  input  wire logic        srst_i,
  // register port
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [31:0] reg_rdata_o,
  // card bus
  input  wire logic        sd_clk_i,
  input  wire logic        sd_cmd_i,
  output logic             sd_dat_o,
  output logic             sd_dat_oe_n_o,
  // response
  output logic             resp_valid_o,
  output logic      [5:0]  resp_index_o,
  output logic      [31:0] resp_status_o,
  output logic             resp_busy_o,
  output logic             busy_o,
  output logic             app_cmd_o,
  // data engine
  output logic             data_start_o,
  output logic             data_dir_o,
  output logic      [15:0] data_len_o,
  // erase
  output logic             erase_go_o,
  output logic      [1:0]  erase_mode_o,
  output logic      [31:0] erase_first_o,
  output logic      [31:0] erase_last_o
);
  localparam int GW = $clog2(NUM_GROUPS);

  function automatic logic is_reserved(input logic [5:0] i);
    return (i == 6'h1F) || (i == 6'h27) || (i == 6'h29) || (i == 6'h33) || (i >= 6'h3C);
  endfunction

  function automatic logic is_ours(input logic [5:0] i);
    return (i == card_cmd_pkg::CMD_SET_PROT) || (i == card_cmd_pkg::CMD_CLR_PROT) ||
           (i == card_cmd_pkg::CMD_SEND_PROT) || (i == card_cmd_pkg::CMD_ERASE_FIRST) ||
           (i == card_cmd_pkg::CMD_ERASE_LAST) || (i == card_cmd_pkg::CMD_ERASE) ||
           (i == card_cmd_pkg::CMD_LOCKED_RD) || (i == card_cmd_pkg::CMD_LOCK) ||
           (i == card_cmd_pkg::CMD_APP) || (i == card_cmd_pkg::CMD_GENERAL);
  endfunction

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b);
    return {c[14:0], 1'b0} ^ ((c[15] ^ b) ? card_cmd_pkg::CRC16_POLY : 16'h0000);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // pin sampling; clk_s1 and cmd_s1 feed only the second stage
  logic clk_s1;
  logic clk_s2;
  logic clk_s3;
  logic cmd_s1;
  logic cmd_s2;

  always_ff @(posedge clk_sys_i) begin
    clk_s1 <= sd_clk_i;
    clk_s2 <= clk_s1;
    clk_s3 <= clk_s2;
    cmd_s1 <= sd_cmd_i;
    cmd_s2 <= cmd_s1;
  end

  wire sd_rise = clk_s2 & ~clk_s3;
  wire sd_fall = ~clk_s2 & clk_s3;

  ////////////////////////////////////////////////////////////////////////////////
  // command frame receiver, 48 bits on card clock rising edges
  logic        rx_busy;
  logic [5:0]  rx_cnt;
  logic [47:0] rx_sh;
  logic        frame_done;

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      rx_busy    <= 1'b0;
      rx_cnt     <= 6'h00;
      rx_sh      <= 48'h0000_0000_0000;
      frame_done <= 1'b0;
    end else begin
      frame_done <= 1'b0;
      if (sd_rise && !rx_busy && !cmd_s2) begin
        rx_busy <= 1'b1;
        rx_cnt  <= 6'h01;
        rx_sh   <= 48'h0000_0000_0000;
      end else if (sd_rise && rx_busy) begin
        rx_sh  <= {rx_sh[46:0], cmd_s2};
        rx_cnt <= rx_cnt + 6'h01;
        if (rx_cnt == card_cmd_pkg::FRAME_LAST) begin
          rx_busy    <= 1'b0;
          frame_done <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // configuration and decode
  logic [31:0] cfg;
  logic [15:0] blk_len;

  wire        cap      = cfg[card_cmd_pkg::CFG_CAP];
  wire        wp_feat  = cfg[card_cmd_pkg::CFG_WP];
  wire        partial  = cfg[card_cmd_pkg::CFG_PARTIAL];
  wire        rd_cross = cfg[card_cmd_pkg::CFG_RD_CROSS];
  wire        wr_cross = cfg[card_cmd_pkg::CFG_WR_CROSS];
  wire        locked   = cfg[card_cmd_pkg::CFG_LOCK];
  wire [3:0]  grp_sh   = cfg[card_cmd_pkg::CFG_GRP_LSB +: card_cmd_pkg::CFG_GRP_W];
  wire [15:0] rel_addr = cfg[card_cmd_pkg::CFG_ADDR_LSB +: 16];

  wire [5:0]  idx      = rx_sh[45:40];
  wire [31:0] arg      = rx_sh[39:8];
  // crc7 is not checked here; framing bits only
  wire        frame_ok = frame_done & ~rx_sh[47] & rx_sh[46] & rx_sh[0];

  wire [31:0] blk_addr = cap ? arg : (arg >> card_cmd_pkg::UNIT_SHIFT); // [RULE2]
  wire [31:0] grp      = blk_addr >> grp_sh; // [RULE5]
  wire        grp_in   = grp < 32'(NUM_GROUPS);
  wire [GW-1:0] gsel   = grp[GW-1:0];

  wire is_wp   = (idx == card_cmd_pkg::CMD_SET_PROT) | (idx == card_cmd_pkg::CMD_CLR_PROT) |
                 (idx == card_cmd_pkg::CMD_SEND_PROT);
  wire is_ers  = (idx == card_cmd_pkg::CMD_ERASE_FIRST) | (idx == card_cmd_pkg::CMD_ERASE_LAST) |
                 (idx == card_cmd_pkg::CMD_ERASE);
  wire wp_bad  = is_wp & (cap | ~wp_feat); // [RULE7]
  // command 40 is left out of the lock filter [RULE14]
  wire lock_bad = locked & (is_wp | is_ers);
  wire take    = frame_ok & is_ours(idx) & ~wp_bad & ~lock_bad;
  wire drop    = frame_ok & (is_reserved(idx) | (is_ours(idx) & (wp_bad | lock_bad))); // [RULE22]
  wire r1b     = (idx == card_cmd_pkg::CMD_SET_PROT) | (idx == card_cmd_pkg::CMD_CLR_PROT) |
                 (idx == card_cmd_pkg::CMD_ERASE); // [RULE4] [RULE6] [RULE13]

  ////////////////////////////////////////////////////////////////////////////////
  // data transfer sizing
  wire is_lock = idx == card_cmd_pkg::CMD_LOCK;
  wire is_gen  = idx == card_cmd_pkg::CMD_GENERAL;
  wire is_rd40 = idx == card_cmd_pkg::CMD_LOCKED_RD;
  wire is_data = is_lock | is_gen | is_rd40;
  wire to_card = is_lock | (is_gen & ~arg[0]); // [RULE18]
  wire [15:0] std_len  = (to_card & ~partial) ? card_cmd_pkg::DEFAULT_LEN : blk_len; // [RULE3]
  wire [15:0] xfer_len = is_lock ? blk_len : (cap ? card_cmd_pkg::FIXED_LEN : std_len); // [RULE15] [RULE19]
  wire        len_err  = is_data & (xfer_len > card_cmd_pkg::MAX_LEN); // [RULE20]
  // only the addressed read carries a byte offset into its block
  wire [15:0] offset   = (is_rd40 & ~cap) ? {7'h00, arg[8:0]} : 16'h0000;
  wire [16:0] span_end = {1'b0, offset} + {1'b0, xfer_len};
  wire        cross_ok = to_card ? wr_cross : rd_cross;
  wire        mis_err  = is_data & (span_end > card_cmd_pkg::PHYS_BLOCK) & ~cross_ok; // [RULE1]
  wire        xfer_go  = take & is_data & ~len_err & ~mis_err;
  wire        app_hit  = (idx == card_cmd_pkg::CMD_APP) & (arg[31:16] == rel_addr); // [RULE17]

  wire [1:0] next_mode = (arg == card_cmd_pkg::ERASE_ARG_DISC) ? card_cmd_pkg::ERASE_DISCARD :
                         (arg == card_cmd_pkg::ERASE_ARG_FULL) ? card_cmd_pkg::ERASE_FULL :
                         card_cmd_pkg::ERASE_NORMAL; // [RULE13]

  logic st_ill;
  logic st_blk;
  logic st_addr;

  wire [31:0] next_status = (32'(mis_err) << card_cmd_pkg::R1_ADDR) |
                            (32'(len_err) << card_cmd_pkg::R1_BLKLEN) |
                            (32'(locked) << card_cmd_pkg::R1_LOCKED) |
                            (32'(st_ill) << card_cmd_pkg::R1_ILLEGAL) |
                            (32'(app_hit) << card_cmd_pkg::R1_APP);

  ////////////////////////////////////////////////////////////////////////////////
  // responses, erase range, transfer requests
  logic [7:0] busy_cnt;
  wire  [7:0] next_busy = (take & r1b) ? card_cmd_pkg::BUSY_CYCLES :
                          (busy_cnt != 8'h00) ? busy_cnt - 8'h01 : 8'h00;

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      resp_valid_o  <= 1'b0;
      resp_index_o  <= 6'h00;
      resp_status_o <= 32'h0000_0000;
      resp_busy_o   <= 1'b0;
      app_cmd_o     <= 1'b0;
      busy_cnt      <= 8'h00;
      busy_o        <= 1'b0;
      erase_go_o    <= 1'b0;
      erase_mode_o  <= card_cmd_pkg::ERASE_NORMAL;
      erase_first_o <= 32'h0000_0000;
      erase_last_o  <= 32'h0000_0000;
      data_start_o  <= 1'b0;
      data_dir_o    <= 1'b0;
      data_len_o    <= 16'h0000;
    end else begin
      resp_valid_o <= take;
      data_start_o <= xfer_go;
      erase_go_o   <= take & (idx == card_cmd_pkg::CMD_ERASE);
      busy_cnt     <= next_busy;
      busy_o       <= next_busy != 8'h00;
      if (frame_ok) begin
        app_cmd_o <= take & app_hit; // [RULE17]
      end
      if (take) begin
        resp_index_o  <= idx;
        resp_status_o <= next_status;
        resp_busy_o   <= r1b;
      end
      if (take && idx == card_cmd_pkg::CMD_ERASE_FIRST) begin
        erase_first_o <= arg; // [RULE11]
      end
      if (take && idx == card_cmd_pkg::CMD_ERASE_LAST) begin
        erase_last_o <= arg; // [RULE12]
      end
      if (take && idx == card_cmd_pkg::CMD_ERASE) begin
        erase_mode_o <= next_mode;
      end
      if (xfer_go) begin
        data_dir_o <= ~to_card;
        data_len_o <= xfer_len;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // protection groups
  logic [NUM_GROUPS-1:0] prot;
  logic [31:0]           payload;

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      prot <= {NUM_GROUPS{1'b0}};
    end else if (take && grp_in && idx == card_cmd_pkg::CMD_SET_PROT) begin
      prot[gsel] <= 1'b1; // [RULE4]
    end else if (take && grp_in && idx == card_cmd_pkg::CMD_CLR_PROT) begin
      prot[gsel] <= 1'b0; // [RULE6]
    end
  end

  for (genvar gi = 0; gi < 32; gi++) begin : g_payload
    wire [32:0] gn = {1'b0, grp} + 33'(gi);
    assign payload[gi] = (gn < 33'(NUM_GROUPS)) ? prot[gn[GW-1:0]] : 1'b0; // [RULE9] [RULE10]
  end

  ////////////////////////////////////////////////////////////////////////////////
  // status payload on the data line, driven after card clock falling edges
  card_cmd_pkg::tx_state_e tx_state;
  logic [5:0]  tx_cnt;
  logic [31:0] tx_sh;
  logic [15:0] crc;
  logic        tx_req;

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      tx_state      <= card_cmd_pkg::TX_IDLE;
      tx_cnt        <= 6'h00;
      tx_sh         <= 32'h0000_0000;
      crc           <= 16'h0000;
      tx_req        <= 1'b0;
      sd_dat_o      <= 1'b1;
      sd_dat_oe_n_o <= 1'b1;
    end else begin
      if (take && idx == card_cmd_pkg::CMD_SEND_PROT) begin
        tx_req <= 1'b1;
        tx_sh  <= payload; // [RULE8]
      end
      case (tx_state)
        card_cmd_pkg::TX_IDLE: begin
          if (sd_fall && tx_req) begin
            tx_req        <= 1'b0;
            tx_cnt        <= 6'h00;
            crc           <= 16'h0000;
            sd_dat_o      <= 1'b0;
            sd_dat_oe_n_o <= 1'b0;
            tx_state      <= card_cmd_pkg::TX_START;
          end
        end
        card_cmd_pkg::TX_START, card_cmd_pkg::TX_DATA: begin
          if (sd_fall && tx_cnt == card_cmd_pkg::PROT_BITS) begin
            sd_dat_o <= crc[15];
            crc      <= {crc[14:0], 1'b0};
            tx_cnt   <= 6'h01;
            tx_state <= card_cmd_pkg::TX_CRC;
          end else if (sd_fall) begin
            // msb first so the first group's bit goes out last [RULE9]
            sd_dat_o <= tx_sh[31];
            tx_sh    <= {tx_sh[30:0], 1'b0};
            crc      <= crc_step(crc, tx_sh[31]);
            tx_cnt   <= tx_cnt + 6'h01;
            tx_state <= card_cmd_pkg::TX_DATA;
          end
        end
        card_cmd_pkg::TX_CRC: begin
          if (sd_fall && tx_cnt == card_cmd_pkg::CRC_BITS) begin
            sd_dat_o <= 1'b1;
            tx_state <= card_cmd_pkg::TX_END;
          end else if (sd_fall) begin
            sd_dat_o <= crc[15];
            crc      <= {crc[14:0], 1'b0};
            tx_cnt   <= tx_cnt + 6'h01;
          end
        end
        card_cmd_pkg::TX_END: begin
          if (sd_fall) begin
            sd_dat_oe_n_o <= 1'b1;
            tx_state      <= card_cmd_pkg::TX_IDLE;
          end
        end
        default: begin
          tx_state <= card_cmd_pkg::TX_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // register port
  wire w_cfg = reg_wr_i && reg_addr_i == card_cmd_pkg::REG_CONFIG;
  wire w_len = reg_wr_i && reg_addr_i == card_cmd_pkg::REG_BLOCK_LEN;
  wire w_st  = reg_wr_i && reg_addr_i == card_cmd_pkg::REG_STATUS;
  wire tx_on = tx_state != card_cmd_pkg::TX_IDLE;

  wire [31:0] status_word = (32'(st_ill) << card_cmd_pkg::ST_ILLEGAL) |
                            (32'(st_blk) << card_cmd_pkg::ST_BLKLEN) |
                            (32'(st_addr) << card_cmd_pkg::ST_ADDR) |
                            (32'(app_cmd_o) << card_cmd_pkg::ST_APP) |
                            (32'(locked) << card_cmd_pkg::ST_LOCKED) |
                            (32'(busy_o) << card_cmd_pkg::ST_BUSY) |
                            (32'(tx_on) << card_cmd_pkg::ST_TX) |
                            (32'(erase_mode_o) << card_cmd_pkg::ST_MODE_LSB);

  wire [31:0] rd_mux = (reg_addr_i == card_cmd_pkg::REG_CONFIG) ? cfg :
                       (reg_addr_i == card_cmd_pkg::REG_BLOCK_LEN) ? {16'h0000, blk_len} :
                       (reg_addr_i == card_cmd_pkg::REG_STATUS) ? status_word :
                       (reg_addr_i == card_cmd_pkg::REG_ERASE_FIRST) ? erase_first_o :
                       (reg_addr_i == card_cmd_pkg::REG_ERASE_LAST) ? erase_last_o :
                       32'h0000_0000;

  wire set_ill  = drop;
  wire set_blk  = take & len_err; // [RULE20]
  wire set_addr = take & mis_err;

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      cfg         <= card_cmd_pkg::CONFIG_RESET;
      blk_len     <= card_cmd_pkg::BLOCK_LEN_RESET;
      reg_rdata_o <= 32'h0000_0000;
      st_ill      <= 1'b0;
      st_blk      <= 1'b0;
      st_addr     <= 1'b0;
    end else begin
      reg_rdata_o <= reg_rd_i ? rd_mux : 32'h0000_0000;
      if (w_cfg) begin
        cfg <= reg_wdata_i;
      end
      if (w_len) begin
        blk_len <= reg_wdata_i[15:0];
      end
      // write one to clear; a new event in the same cycle wins
      st_ill  <= set_ill | (st_ill & ~(w_st & reg_wdata_i[card_cmd_pkg::ST_ILLEGAL]));
      st_blk  <= set_blk | (st_blk & ~(w_st & reg_wdata_i[card_cmd_pkg::ST_BLKLEN]));
      st_addr <= set_addr | (st_addr & ~(w_st & reg_wdata_i[card_cmd_pkg::ST_ADDR]));
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);

  property p_set_busy;
    take && idx == card_cmd_pkg::CMD_SET_PROT && grp_in |=> resp_busy_o && prot[$past(gsel)];
  endproperty
  a_set_busy: assert property (p_set_busy) else $error("set protect failed"); // [RULE4]

  property p_clr_bit;
    take && idx == card_cmd_pkg::CMD_CLR_PROT && grp_in |=> resp_busy_o && !prot[$past(gsel)];
  endproperty
  a_clr_bit: assert property (p_clr_bit) else $error("clear protect failed"); // [RULE6]

  property p_hc_no_wp;
    frame_ok && cap && is_wp |=> !resp_valid_o && st_ill;
  endproperty
  a_hc_no_wp: assert property (p_hc_no_wp) else $error("protect cmd taken on hc card"); // [RULE7]

  property p_erase_mode;
    take && idx == card_cmd_pkg::CMD_ERASE && arg == card_cmd_pkg::ERASE_ARG_FULL
      |=> erase_go_o && resp_busy_o && erase_mode_o == card_cmd_pkg::ERASE_FULL;
  endproperty
  a_erase_mode: assert property (p_erase_mode) else $error("erase mode wrong"); // [RULE13]

  property p_first_store;
    take && idx == card_cmd_pkg::CMD_ERASE_FIRST |=> erase_first_o == $past(arg) && !resp_busy_o;
  endproperty
  a_first_store: assert property (p_first_store) else $error("first erase addr lost"); // [RULE11]

  property p_hc_len;
    xfer_go && cap && is_gen |=> data_start_o && data_len_o == card_cmd_pkg::FIXED_LEN;
  endproperty
  a_hc_len: assert property (p_hc_len) else $error("hc general length wrong"); // [RULE19]

  property p_len_err;
    take && len_err |=> !data_start_o ##1 st_blk;
  endproperty
  a_len_err: assert property (p_len_err) else $error("long block not flagged"); // [RULE20]

  property p_reserved;
    frame_ok && is_reserved(idx) |=> !resp_valid_o && !data_start_o && !erase_go_o;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved cmd acted"); // [RULE22]

  property p_locked_rd;
    frame_ok && locked && is_rd40 |=> resp_valid_o;
  endproperty
  a_locked_rd: assert property (p_locked_rd) else $error("cmd40 refused when locked"); // [RULE14]

  property p_prot_tx;
    take && idx == card_cmd_pkg::CMD_SEND_PROT |-> ##[1:40] !sd_dat_oe_n_o;
  endproperty
  a_prot_tx: assert property (p_prot_tx) else $error("status payload not started"); // [RULE8]

  property p_app;
    frame_ok && app_hit |=> app_cmd_o && resp_status_o[card_cmd_pkg::R1_APP];
  endproperty
  a_app: assert property (p_app) else $error("app prefix not marked"); // [RULE17]

  c_erase: cover property (take && idx == card_cmd_pkg::CMD_ERASE);
  c_prot_send: cover property (tx_state == card_cmd_pkg::TX_END);
  c_gen_read: cover property (xfer_go && is_gen && arg[0]);
  c_app_next: cover property (app_cmd_o && frame_ok);
endmodule // card_cmd_core

// [verilog/card_cmd_pkg.sv]
package card_cmd_pkg;
  // register map, byte offsets
  localparam logic [7:0]  REG_CONFIG      = 8'h00;
  localparam logic [7:0]  REG_BLOCK_LEN   = 8'h04;
  localparam logic [7:0]  REG_STATUS      = 8'h08;
  localparam logic [7:0]  REG_ERASE_FIRST = 8'h0C;
  localparam logic [7:0]  REG_ERASE_LAST  = 8'h10;
  // config fields
  localparam int          CFG_CAP         = 0;
  localparam int          CFG_WP          = 1;
  localparam int          CFG_PARTIAL     = 2;
  localparam int          CFG_RD_CROSS    = 3;
  localparam int          CFG_WR_CROSS    = 4;
  localparam int          CFG_LOCK        = 5;
  localparam int          CFG_GRP_LSB     = 8;
  localparam int          CFG_GRP_W       = 4;
  localparam int          CFG_ADDR_LSB    = 16;
  localparam logic [31:0] CONFIG_RESET    = 32'h0000_0002;
  localparam logic [15:0] BLOCK_LEN_RESET = 16'h0200;
  localparam logic [15:0] DEFAULT_LEN     = 16'h0200;
  localparam logic [15:0] FIXED_LEN       = 16'h0200;
  localparam logic [15:0] MAX_LEN         = 16'h0200;
  localparam logic [16:0] PHYS_BLOCK      = 17'h0_0200;
  localparam int          UNIT_SHIFT      = 9;
  // status register bits
  localparam int          ST_ILLEGAL      = 0;
  localparam int          ST_BLKLEN       = 1;
  localparam int          ST_ADDR         = 2;
  localparam int          ST_APP          = 3;
  localparam int          ST_LOCKED       = 4;
  localparam int          ST_BUSY         = 5;
  localparam int          ST_TX           = 6;
  localparam int          ST_MODE_LSB     = 8;
  // card status bits in the response
  localparam int          R1_ADDR         = 30;
  localparam int          R1_BLKLEN       = 29;
  localparam int          R1_LOCKED       = 25;
  localparam int          R1_ILLEGAL      = 22;
  localparam int          R1_APP          = 5;
  // command indices
  localparam logic [5:0]  CMD_SET_PROT    = 6'h1C;
  localparam logic [5:0]  CMD_CLR_PROT    = 6'h1D;
  localparam logic [5:0]  CMD_SEND_PROT   = 6'h1E;
  localparam logic [5:0]  CMD_ERASE_FIRST = 6'h20;
  localparam logic [5:0]  CMD_ERASE_LAST  = 6'h21;
  localparam logic [5:0]  CMD_ERASE       = 6'h26;
  localparam logic [5:0]  CMD_LOCKED_RD   = 6'h28;
  localparam logic [5:0]  CMD_LOCK        = 6'h2A;
  localparam logic [5:0]  CMD_APP         = 6'h37;
  localparam logic [5:0]  CMD_GENERAL     = 6'h38;
  // erase function argument codes
  localparam logic [31:0] ERASE_ARG_DISC  = 32'h0000_0001;
  localparam logic [31:0] ERASE_ARG_FULL  = 32'h0000_0002;
  typedef enum logic [1:0] {
    ERASE_NORMAL  = 2'h0,
    ERASE_DISCARD = 2'h1,
    ERASE_FULL    = 2'h2
  } erase_mode_e;
  // busy hold after a busy-type response
  localparam int          BUSY_TIME_NS    = 1000;
  localparam int          CLK_PERIOD_NS   = 8;
  localparam logic [7:0]  BUSY_CYCLES     =
    8'((BUSY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  // framing
  localparam logic [5:0]  FRAME_LAST      = 6'h2F;
  localparam logic [5:0]  PROT_BITS       = 6'h20;
  localparam logic [5:0]  CRC_BITS        = 6'h10;
  localparam logic [15:0] CRC16_POLY      = 16'h1021;
  typedef enum logic [4:0] {
    TX_IDLE  = 5'b00001,
    TX_START = 5'b00010,
    TX_DATA  = 5'b00100,
    TX_CRC   = 5'b01000,
    TX_END   = 5'b10000
  } tx_state_e;
endpackage
